//--- design/hub_config_power.sv
// hub strap decode, port power, clock select, pull-up timing and register slave
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hub_consts.svh"
// Operation
// - memory strap high: default ids, gang pin
// - memory strap low: ids and gang from eeprom
// - overcurrent switches off its port power
// - ganged: all enables together, any overcurrent
// - per-port: own enable, own overcurrent only
// - clock strap low: core from pll
// - clock strap high: direct clock, pll/osc off
// - pll multiplies 6 MHz to 48 MHz
// - port strap low: three ports, high: two
// - fixed count 00 none, 01 port 1
// - fixed count 10 gives ports 1 and 2
// - fixed count 11 depends on port count
// - compound bit set unless fixed count 00
// - slew rate follows attached device speed
// - pull-up held off 3 ms after reset/change
// - power source input picks bus/self power
module hub_config_power
  import hub_pkg::*;
#(
  parameter int unsigned PULLUP_CYCLES = `PULLUP_CYCLES,
  parameter int unsigned PORTS         = 3
) (
  input  wire logic             clk_i,                       // core clock, 100 MHz
  input  wire logic             rst_i,                       // synchronous reset, active high
  input  wire logic             cyc_i,                       // wishbone cycle
  input  wire logic             stb_i,                       // wishbone strobe
  input  wire logic             we_i,                        // wishbone write
  input  wire logic [7:0]       adr_i,                       // wishbone byte address
  input  wire logic [3:0]       sel_i,                       // wishbone byte lanes
  input  wire logic [31:0]      dat_i,                       // wishbone write data
  output logic      [31:0]      dat_o,                       // wishbone read data
  output logic                  ack_o,                       // wishbone acknowledge
  output logic                  irq_o,                       // interrupt, level
  input  wire logic             external_memory_select_i,    // strap: high uses default ids
  input  wire logic             clock_mode_i,                // strap: high direct clock
  input  wire logic             three_port_select_n_i,       // strap: low three ports
  input  wire logic [1:0]       fixed_port_count_i,          // strap: permanently attached ports
  input  wire logic             power_source_select_i,       // high self powered
  output logic                  eeprom_clock_out_o,          // eeprom clock level
  output logic                  eeprom_clock_out_oe_o,       // eeprom clock drive enable
  input  wire logic             eeprom_data_io_i,            // shared data or gang pin level
  output logic                  eeprom_data_io_o,            // eeprom data level
  output logic                  eeprom_data_io_oe_o,         // eeprom data drive enable
  input  wire logic [PORTS-1:0] port_overcurrent_in_n_i,     // overcurrent, active low
  output logic      [PORTS-1:0] port_power_enable_o,         // port power enables
  input  wire logic [PORTS-1:0] port_low_speed_i,            // attached device is low speed
  output logic      [PORTS-1:0] slew_slow_o,                 // slow edge rate select
  output logic                  core_clk_direct_o,           // core clock from input pin
  output logic                  clock_multiplier_pll_on_o,   // pll powered
  output logic                  oscillator_on_o,             // oscillator cell powered
  output logic      [3:0]       pll_mult_o,                  // pll multiply factor
  input  wire logic             suspend_req_i,               // hub core enters suspend
  output logic                  suspend_status_out_o,        // suspend status
  output logic                  upstream_pullup_enable_o,    // upstream pull-up enable
  output logic                  self_powered_o,              // self powered mode
  output logic                  ganged_o,                    // ganged power mode
  output logic                  three_port_o,                // three-port hub
  output logic                  compound_o,                  // compound device bit
  output logic      [7:0]       removable_o,                 // removable device field
  output logic      [15:0]      vendor_id_o,                 // reported vendor id
  output logic      [15:0]      product_id_o                 // reported product id
);
  // captured straps
  logic         captured;
  logic         ext_mem;
  logic         clk_direct;
  logic         three_port;
  fixed_count_t fixed_cnt;
  logic         gang_pin;
  logic         next_captured;
  logic         next_ext_mem;
  logic         next_clk_direct;
  logic         next_three_port;
  fixed_count_t next_fixed_cnt;
  logic         next_gang_pin;

  // software state
  logic [PORTS-1:0]       ctrl;
  logic [`ST_WIDTH-1:0]   status;
  logic [`ST_WIDTH-1:0]   mask;
  logic [31:0]            ee_id;
  logic [4:0]             ee_pins;
  logic [PORTS-1:0]       next_ctrl;
  logic [`ST_WIDTH-1:0]   next_status;
  logic [`ST_WIDTH-1:0]   next_mask;
  logic [31:0]            next_ee_id;
  logic [4:0]             next_ee_pins;
  logic                   next_ack;
  logic [31:0]            next_dat;

  // derived configuration
  logic                   ganged;
  removable_t             removable;
  logic [PORTS-1:0]       present;
  logic [PORTS-1:0]       oc_rise;
  logic [PORTS-1:0]       oc_level;
  logic                   pullup_ready;
  logic                   pwr_change;
  logic                   req;
  logic [`ST_WIDTH-1:0]   events;
  logic [31:0]            strap_word;

  assign req = cyc_i && stb_i && !ack_o;

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wr[8*b +: 8];
      end
    end
    return res;
  endfunction

  // straps are read once after reset so a pin bouncing later cannot move the descriptor
  always_comb begin
    next_captured   = 1'b1;
    next_ext_mem    = ext_mem;
    next_clk_direct = clk_direct;
    next_three_port = three_port;
    next_fixed_cnt  = fixed_cnt;
    next_gang_pin   = gang_pin;
    if (!captured) begin
      next_ext_mem    = external_memory_select_i;
      next_clk_direct = clock_mode_i;
      next_three_port = !three_port_select_n_i;
      next_fixed_cnt  = fixed_port_count_i;
      next_gang_pin   = eeprom_data_io_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      captured   <= 1'b0;
      ext_mem    <= 1'b1;
      clk_direct <= 1'b0;
      three_port <= 1'b1;
      fixed_cnt  <= 2'h0;
      gang_pin   <= 1'b0;
    end else begin
      captured   <= next_captured;
      ext_mem    <= next_ext_mem;
      clk_direct <= next_clk_direct;
      three_port <= next_three_port;
      fixed_cnt  <= next_fixed_cnt;
      gang_pin   <= next_gang_pin;
    end
  end

  // the shared pin is the gang input only while the eeprom is not in use
  assign ganged = ext_mem ? gang_pin : ee_pins[`PIN_GANG_BIT];

  always_comb begin
    unique case (fixed_cnt)
      2'h0: removable = `RMV_NONE;
      2'h1: removable = `RMV_PORT1;
      2'h2: removable = `RMV_PORT12;
      2'h3: removable = three_port ? `RMV_PORT123 : `RMV_PORT12;
    endcase
  end

  // port 3 is not powered in two-port mode
  assign present = {three_port, 2'h3};

  port_power #(
    .PORTS  (PORTS),
    .FILTER (`OC_FILTER_CYCLES)
  ) u_power (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ganged_i  (ganged),
    .present_i (present),
    .request_i (ctrl),
    .oc_n_i    (port_overcurrent_in_n_i),
    .enable_o  (port_power_enable_o),
    .oc_o      (oc_level),
    .oc_rise_o (oc_rise)
  );

  pullup_timer #(
    .HOLD_CYCLES (PULLUP_CYCLES)
  ) u_pullup (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .power_src_i    (power_source_select_i),
    .pullup_o       (upstream_pullup_enable_o),
    .ready_pulse_o  (pullup_ready),
    .change_pulse_o (pwr_change)
  );

  assign events = {pwr_change, pullup_ready, oc_rise};
  assign strap_word = {16'h0000, removable, self_powered_o, compound_o, fixed_cnt,
                       three_port, clk_direct, ganged, ext_mem};

  // register bus; a request is answered one cycle after it is seen
  always_comb begin
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_ee_id   = ee_id;
    next_ee_pins = ee_pins;
    next_status  = status;
    next_ack     = req;
    next_dat     = 32'h0000_0000;
    if (req && we_i) begin
      unique case (adr_i)
        `REG_CTRL: next_ctrl = PORTS'(lanes(32'(ctrl), dat_i, sel_i));
        `REG_STATUS: next_status = status & ~(sel_i[0] ? dat_i[`ST_WIDTH-1:0] : 5'h00);
        `REG_MASK: next_mask = 5'(lanes({27'h0, mask}, dat_i, sel_i));
        `REG_EE_ID: next_ee_id = lanes(ee_id, dat_i, sel_i);
        `REG_EE_PINS: next_ee_pins = 5'(lanes({27'h0, ee_pins}, dat_i, sel_i));
        default: next_dat = 32'h0000_0000;
      endcase
    end
    if (req && !we_i) begin
      unique case (adr_i)
        `REG_CTRL: next_dat = {29'h0, ctrl};
        `REG_STATUS: next_dat = {27'h0, status};
        `REG_MASK: next_dat = {27'h0, mask};
        `REG_STRAP: next_dat = strap_word;
        `REG_ID: next_dat = {product_id_o, vendor_id_o};
        `REG_EE_ID: next_dat = ee_id;
        `REG_EE_PINS: next_dat = {27'h0, ee_pins[4], eeprom_data_io_i, ee_pins[2:0]};
        default: next_dat = 32'h0000_0000;
      endcase
    end
    // an event in the clearing cycle survives the clear
    next_status = next_status | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= `CTRL_RST;
      status  <= '0;
      mask    <= '0;
      ee_id   <= `EE_ID_RST;
      ee_pins <= 5'h00;
      ack_o   <= 1'b0;
      dat_o   <= 32'h0000_0000;
      irq_o   <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      status  <= next_status;
      mask    <= next_mask;
      ee_id   <= next_ee_id;
      ee_pins <= next_ee_pins;
      ack_o   <= next_ack;
      dat_o   <= next_dat;
      irq_o   <= |(next_status & next_mask);
    end
  end

  // configuration outputs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vendor_id_o               <= `DEFAULT_VID;
      product_id_o              <= `DEFAULT_PID;
      removable_o               <= `RMV_NONE;
      compound_o                <= 1'b0;
      ganged_o                  <= 1'b0;
      three_port_o              <= 1'b1;
      self_powered_o            <= 1'b0;
      core_clk_direct_o         <= 1'b0;
      clock_multiplier_pll_on_o <= 1'b1;
      oscillator_on_o           <= 1'b1;
      pll_mult_o                <= `PLL_MULT;
      slew_slow_o               <= '0;
      suspend_status_out_o      <= 1'b0;
      eeprom_clock_out_o        <= 1'b0;
      eeprom_clock_out_oe_o     <= 1'b0;
      eeprom_data_io_o          <= 1'b0;
      eeprom_data_io_oe_o       <= 1'b0;
    end else begin
      vendor_id_o               <= ext_mem ? `DEFAULT_VID : ee_id[15:0];
      product_id_o              <= ext_mem ? `DEFAULT_PID : ee_id[31:16];
      removable_o               <= removable;
      compound_o                <= fixed_cnt != 2'h0;
      ganged_o                  <= ganged;
      three_port_o              <= three_port;
      self_powered_o            <= power_source_select_i;
      core_clk_direct_o         <= clk_direct;
      clock_multiplier_pll_on_o <= !clk_direct;
      oscillator_on_o           <= !clk_direct;
      pll_mult_o                <= `PLL_MULT;
      slew_slow_o               <= port_low_speed_i;
      // the board must stop a 6 MHz oscillator while this is high
      suspend_status_out_o      <= suspend_req_i;
      // eeprom pins are driven only while the eeprom is selected
      eeprom_clock_out_o        <= !ext_mem && ee_pins[`PIN_CLK_BIT];
      eeprom_clock_out_oe_o     <= !ext_mem;
      eeprom_data_io_o          <= !ext_mem && ee_pins[`PIN_DOUT_BIT];
      eeprom_data_io_oe_o       <= !ext_mem && ee_pins[`PIN_DOE_BIT];
    end
  end

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged in one cycle");
  rmv_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (captured && fixed_cnt == 2'h2) |=> removable_o == 8'h06)
    else $error("removable field wrong for two fixed ports");
  rmv_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (captured && fixed_cnt == 2'h3 && three_port) |=> removable_o == 8'h0E)
    else $error("removable field wrong for three fixed ports");
  compound_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (captured && fixed_cnt == 2'h0) |=> !compound_o)
    else $error("compound bit set with no fixed ports");
  clock_direct_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_direct |=> (!clock_multiplier_pll_on_o && !oscillator_on_o && core_clk_direct_o))
    else $error("pll or oscillator powered in direct clock mode");
  strap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    captured |=> $stable(fixed_cnt) && $stable(three_port) && $stable(ext_mem))
    else $error("captured straps changed");
  default_id_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (captured && ext_mem) |=> (vendor_id_o == `DEFAULT_VID && !eeprom_clock_out_oe_o))
    else $error("default ids or idle eeprom clock not used");
  oc_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_rise[0] |=> status[0])
    else $error("overcurrent event lost");
endmodule
`default_nettype wire

//--- design/hub_consts.svh
// constants for the hub configuration and port power block
`ifndef HUB_CONSTS_SVH
`define HUB_CONSTS_SVH

`define CLK_MHZ          100
`define PULLUP_TIME_US   3000
`define PULLUP_CYCLES    (`PULLUP_TIME_US * `CLK_MHZ)
`define OC_FILTER_CYCLES 4
`define PLL_REF_MHZ      6
`define PLL_OUT_MHZ      48
`define PLL_MULT         4'h8

`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_MASK         8'h08
`define REG_STRAP        8'h0C
`define REG_ID           8'h10
`define REG_EE_ID        8'h14
`define REG_EE_PINS      8'h18

`define CTRL_RST         3'h0
`define EE_ID_RST        32'h0000_0000
`define DEFAULT_VID      16'h1234
`define DEFAULT_PID      16'h5678

`define ST_OC_LSB        0
`define ST_PULLUP_BIT    3
`define ST_PWRCHG_BIT    4
`define ST_WIDTH         5

`define PIN_CLK_BIT      0
`define PIN_DOUT_BIT     1
`define PIN_DOE_BIT      2
`define PIN_DIN_BIT      3
`define PIN_GANG_BIT     4

`define RMV_NONE         8'h00
`define RMV_PORT1        8'h02
`define RMV_PORT12       8'h06
`define RMV_PORT123      8'h0E
`define COMPOUND_BIT     2

`endif

//--- design/hub_pkg.sv
// types shared by the hub configuration and port power block
package hub_pkg;
  typedef enum logic {PU_HOLD, PU_ON} pullup_state_t;
  typedef logic [1:0] fixed_count_t;
  typedef logic [7:0] removable_t;
endpackage

//--- design/pullup_timer.sv
// upstream pull-up hold-off timer, restarted by reset and by a power source change
`timescale 1ns/1ps
`default_nettype none
module pullup_timer
  import hub_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 300000
) (
  input  wire logic clk_i,         // core clock
  input  wire logic rst_i,         // synchronous reset
  input  wire logic power_src_i,   // power source select level
  output logic      pullup_o,      // pull-up enable
  output logic      ready_pulse_o, // pull-up just enabled
  output logic      change_pulse_o // power source level changed
);
  pullup_state_t state;
  pullup_state_t next_state;
  logic [31:0]   count;
  logic [31:0]   next_count;
  logic          prev_src;
  logic          changed;

  // first cycle after reset may flag a change; it only restarts a count already at zero
  assign changed = prev_src != power_src_i;

  always_comb begin
    next_state = state;
    next_count = count;
    if (changed) begin
      next_state = PU_HOLD;
      next_count = 32'h0000_0000;
    end else if (state == PU_HOLD) begin
      if (count >= HOLD_CYCLES - 1) begin
        next_state = PU_ON;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state          <= PU_HOLD;
      count          <= 32'h0000_0000;
      prev_src       <= 1'b0;
      pullup_o       <= 1'b0;
      ready_pulse_o  <= 1'b0;
      change_pulse_o <= 1'b0;
    end else begin
      state          <= next_state;
      count          <= next_count;
      prev_src       <= power_src_i;
      pullup_o       <= next_state == PU_ON;
      ready_pulse_o  <= next_state == PU_ON && state == PU_HOLD;
      change_pulse_o <= changed;
    end
  end

  pullup_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    changed |=> ##1 !pullup_o)
    else $error("pull-up not dropped after power source change");
  pullup_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == PU_HOLD && count < HOLD_CYCLES - 1) |=> !pullup_o)
    else $error("pull-up enabled before hold time");
endmodule
`default_nettype wire

//--- design/port_power.sv
// per-port overcurrent filter and power enable, ganged or per port
`timescale 1ns/1ps
`default_nettype none
module port_power #(
  parameter int unsigned PORTS  = 3,
  parameter int unsigned FILTER = 4
) (
  input  wire logic             clk_i,      // core clock
  input  wire logic             rst_i,      // synchronous reset
  input  wire logic             ganged_i,   // ganged power mode
  input  wire logic [PORTS-1:0] present_i,  // port exists in this configuration
  input  wire logic [PORTS-1:0] request_i,  // software power request
  input  wire logic [PORTS-1:0] oc_n_i,     // overcurrent, active low
  output logic      [PORTS-1:0] enable_o,   // port power enable
  output logic      [PORTS-1:0] oc_o,       // filtered overcurrent level
  output logic      [PORTS-1:0] oc_rise_o   // overcurrent onset pulse
);
  logic [PORTS-1:0] next_oc;
  logic [PORTS-1:0] next_enable;
  logic             any_oc;

  // spikes shorter than the filter never reach the power outputs
  for (genvar i = 0; i < PORTS; i++) begin : g_port
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    always_comb begin
      next_cnt = 4'h0;
      next_oc[i] = 1'b0;
      if (!oc_n_i[i]) begin
        next_cnt = (cnt >= 4'(FILTER - 1)) ? cnt : cnt + 4'h1;
        next_oc[i] = cnt >= 4'(FILTER - 1);
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt <= 4'h0;
      end else begin
        cnt <= next_cnt;
      end
    end
  end

  assign any_oc = |oc_o;

  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      if (ganged_i) begin
        next_enable[i] = present_i[i] && request_i[0] && !any_oc;
      end else begin
        next_enable[i] = present_i[i] && request_i[i] && !oc_o[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_o      <= '0;
      oc_rise_o <= '0;
      enable_o  <= '0;
    end else begin
      oc_o      <= next_oc;
      oc_rise_o <= next_oc & ~oc_o;
      enable_o  <= next_enable;
    end
  end

  oc_cut_a: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_o[0] |=> !enable_o[0])
    else $error("port power stayed on during overcurrent");
  gang_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ganged_i && any_oc) |=> enable_o == '0)
    else $error("ganged ports not all switched off");
  gang_same_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($stable(ganged_i) && ganged_i && present_i[1]) |=> enable_o[1] == enable_o[0])
    else $error("ganged ports switched apart");
  own_oc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ganged_i && present_i[1] && request_i[1] && !oc_o[1]) |=> enable_o[1])
    else $error("port switched off by another port's overcurrent");
endmodule
`default_nettype wire

//--- tb/hub_far_side.sv
// far side model: downstream power switches and board-level pins
`timescale 1ns/1ps
`default_nettype none
module hub_far_side (
  input  wire logic       clk_i,   // core clock
  input  wire logic [2:0] fault_i, // short present per port
  input  wire logic       mem_i,   // memory strap level
  input  wire logic       gang_i,  // board gang tie
  input  wire logic       dout_i,  // eeprom data out
  input  wire logic       doe_i,   // eeprom data drive enable
  input  wire logic       susp_i,  // suspend status
  output logic      [2:0] oc_n_o,  // overcurrent flags, active low
  output logic            din_o,   // shared pin level
  output logic            osc_o    // external oscillator level
);
  // the switch keeps flagging for as long as the short lasts
  assign oc_n_o = ~fault_i;
  // pulldown wins when nothing drives the pin in eeprom mode
  assign din_o = doe_i ? dout_i : (mem_i ? gang_i : 1'b0);
  assign osc_o = susp_i ? 1'b0 : clk_i;
endmodule
`default_nettype wire

//--- tb/tb.sv
// bench for the hub configuration and port power block
`timescale 1ns/1ps
`default_nettype none
`include "hub_consts.svh"
module tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mem = 1, clkm = 0, np3n = 0;
  logic        psel = 0, gang = 0, susp = 0, ack, irq, din, dout, doe, eck, eck_oe;
  logic        direct, pll_on, osc_on, susp_o, pu, selfp, gng, three, comp, osc;
  logic [1:0]  fix = 2'h3;
  logic [2:0]  fault = 3'h0, ls = 3'h0, oc_n, en, slew;
  logic [3:0]  sel = 4'h0, mult;
  logic [7:0]  adr = 8'h00, rmv;
  logic [15:0] vid, pid;
  logic [31:0] wdat = 32'h0000_0000, rdat, rd_o;
  logic [7:0]  rt [5] = '{8'h00, 8'h02, 8'h06, 8'h0E, 8'h06};
  int          mismatches = 0, n_tests = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  hub_config_power #(.PULLUP_CYCLES(50), .PORTS(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rd_o), .ack_o(ack), .irq_o(irq),
    .external_memory_select_i(mem), .clock_mode_i(clkm), .three_port_select_n_i(np3n), .fixed_port_count_i(fix),
    .power_source_select_i(psel), .eeprom_clock_out_o(eck), .eeprom_clock_out_oe_o(eck_oe),
    .eeprom_data_io_i(din), .eeprom_data_io_o(dout), .eeprom_data_io_oe_o(doe), .port_overcurrent_in_n_i(oc_n),
    .port_power_enable_o(en), .port_low_speed_i(ls), .slew_slow_o(slew), .core_clk_direct_o(direct),
    .clock_multiplier_pll_on_o(pll_on), .oscillator_on_o(osc_on), .pll_mult_o(mult), .suspend_req_i(susp),
    .suspend_status_out_o(susp_o), .upstream_pullup_enable_o(pu), .self_powered_o(selfp), .ganged_o(gng),
    .three_port_o(three), .compound_o(comp), .removable_o(rmv), .vendor_id_o(vid), .product_id_o(pid));
  hub_far_side far (.clk_i(clk_i), .fault_i(fault), .mem_i(mem), .gang_i(gang), .dout_i(dout), .doe_i(doe),
    .susp_i(susp_o), .oc_n_o(oc_n), .din_o(din), .osc_o(osc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // one classic cycle; the slave answers when it likes, the timeout guards a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic boot(input logic m, input logic c, input logic n, input logic g, input logic [1:0] f);
    mem <= m;
    clkm <= c;
    np3n <= n;
    gang <= g;
    fix <= f;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic per_port;
    boot(1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
    chk(vid, `DEFAULT_VID, "default vid");
    chk({eck_oe, doe, gng}, 3'h0, "eeprom pins idle");
    chk({direct, pll_on, osc_on, mult}, {3'b011, 4'h8}, "pll clock");
    repeat (40) @(posedge clk_i);
    chk(pu, 1'b0, "pullup early");
    repeat (27) @(posedge clk_i);
    chk(pu, 1'b1, "pullup late");
    wb(1'b1, `REG_MASK, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1, "irq on pullup");
    wb(1'b1, `REG_STATUS, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0, "irq cleared");
    wb(1'b1, `REG_CTRL, 32'h0000_0007);
    repeat (3) @(posedge clk_i);
    chk(en, 3'h7, "all on");
    fault <= 3'h4;
    repeat (3) @(posedge clk_i);
    fault <= 3'h0;
    repeat (6) @(posedge clk_i);
    chk(en, 3'h7, "glitch ignored");
    fault <= 3'h2;
    repeat (8) @(posedge clk_i);
    chk(en, 3'h5, "own port off");
    wb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk(rdat & 32'h0000_0007, 32'h0000_0002, "onset status");
    wb(1'b1, `REG_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1, "irq on fault");
    fault <= 3'h0;
    repeat (8) @(posedge clk_i);
    chk(en, 3'h7, "port back");
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(rdat, 32'h0000_0000, "unmapped");
    psel <= 1'b1;
    ls <= 3'h5;
    susp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({pu, selfp, slew, susp_o, osc}, 7'h36, "source change");
    repeat (60) @(posedge clk_i);
    chk(pu, 1'b1, "pullup again");
  endtask
  task automatic ganged;
    boot(1'b1, 1'b1, 1'b1, 1'b1, 2'h2);
    chk({gng, three, direct, pll_on, osc_on}, 5'b10100, "direct clock, gang");
    wb(1'b1, `REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(en, 3'h3, "two ports ganged");
    fault <= 3'h1;
    repeat (8) @(posedge clk_i);
    chk(en, 3'h0, "all off");
    fault <= 3'h0;
  endtask
  task automatic eeprom;
    boot(1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
    wb(1'b1, `REG_EE_ID, 32'hBEEF_CAFE);
    repeat (2) @(posedge clk_i);
    chk({pid, vid}, 32'hBEEF_CAFE, "eeprom ids");
    wb(1'b1, `REG_EE_PINS, 32'h0000_0007);
    wb(1'b0, `REG_EE_PINS, 32'h0000_0000);
    chk({eck, doe, rdat[3]}, 3'h7, "eeprom pins");
  endtask
  initial begin
    per_port();
    ganged();
    for (int i = 0; i < 5; i++) begin
      boot(1'b1, 1'b0, i == 4, 1'b0, (i == 4) ? 2'h3 : 2'(i));
      chk({rmv, comp, three}, {rt[i], i != 0, i != 4}, "removable field");
    end
    fix <= 2'h0;
    repeat (3) @(posedge clk_i);
    chk(rmv, 8'h06, "straps held");
    eeprom();
    close_out();
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
endmodule
`default_nettype wire
